// *** pkg/sink_ctrl_pkg.sv ***
`default_nettype none

package sink_ctrl_pkg;

   // Clock and timeouts. Cycle counts are derived from the times at the clock rate.
   localparam int CLK_HZ            = 10_000_000;
   localparam int CLK_MHZ           = CLK_HZ / 1_000_000;
   localparam int LATCH_TIMEOUT_US  = 500;
   localparam int OFF_TIMEOUT_US    = 500;
   localparam int TIMER_W           = 16;

   // The latch timeout is a longest time and the off timeout a least time; both come out whole here.
   localparam logic [TIMER_W-1:0] LATCH_CYCLES_DEF = TIMER_W'(LATCH_TIMEOUT_US * CLK_MHZ);
   localparam logic [TIMER_W-1:0] OFF_CYCLES_DEF   = TIMER_W'(OFF_TIMEOUT_US * CLK_MHZ);
   localparam logic [TIMER_W-1:0] TIMER_ONE        = 16'h0001;
   localparam logic [TIMER_W-1:0] TIMER_FULL       = 16'hffff;

   // Edge counting.
   localparam int                 CNT_W           = 5;
   localparam logic [CNT_W-1:0]   CNT_ZERO        = 5'h00;
   localparam logic [CNT_W-1:0]   CNT_ONE         = 5'h01;
   localparam logic [CNT_W-1:0]   CNT_MAX         = 5'h1f;
   localparam logic [CNT_W-1:0]   DATA_EDGE_MAX   = 5'h10;
   localparam logic [CNT_W-1:0]   ADDR_EDGE_FIRST = 5'h11;
   localparam logic [CNT_W-1:0]   ADDR_EDGE_LAST  = 5'h15;

   // Register addresses; the all-on address holds no data.
   localparam int         NUM_REGS               = 4;
   localparam int         REG_W                  = 4;
   localparam logic [2:0] OFS_BACKLIGHT_CURRENT  = 3'h0;
   localparam logic [2:0] OFS_AUX_CURRENT        = 3'h1;
   localparam logic [2:0] OFS_BACKLIGHT_ONOFF    = 3'h2;
   localparam logic [2:0] OFS_AUX_ONOFF          = 3'h3;
   localparam logic [2:0] OFS_ALL_ON             = 3'h4;
   localparam logic [2:0] ADDR_RESET             = 3'h0;
   localparam logic [REG_W-1:0] REG_RESET        = 4'h0;
   localparam logic [REG_W-1:0] DATA_ONE         = 4'h1;

   // Stored values are the data code minus one; these are the codes for every sink on.
   localparam logic [REG_W-1:0] ALL_ON_BACKLIGHT = 4'h3;
   localparam logic [REG_W-1:0] ALL_ON_AUX       = 4'h7;

   // Sink level in tenths of a percent of full scale, indexed by stored value.
   localparam int LEVEL_W = 10;
   localparam logic [15:0][LEVEL_W-1:0] LEVEL_TABLE = {
      10'h05a, 10'h069, 10'h078, 10'h087, 10'h096, 10'h0b4, 10'h0d2, 10'h104,
      10'h136, 10'h15e, 10'h1ae, 10'h1fe, 10'h258, 10'h2c6, 10'h348, 10'h3e8};
   localparam logic [LEVEL_W-1:0] LEVEL_RESET = 10'h3e8;

   typedef enum logic [1:0] {
      st_off = 2'b01,
      st_on  = 2'b10
   } power_state_type;

endpackage : sink_ctrl_pkg

`default_nettype wire

// *** design/hysteresis_flag.sv ***
`timescale 1ns/10ps
`default_nettype none

module hysteresis_flag
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic trip,
   input  wire logic release_ok,
   output var  logic flag
);

   typedef struct packed {
      logic flag;
   } hyst_state_type;

   hyst_state_type cur;
   hyst_state_type next;

   // A trip seen together with the release keeps the flag set, so no fault is lost.
   always_comb
   begin
      next = cur;
      if (trip)
      begin
         next.flag = 1'b1;
      end
      else if (release_ok)
      begin
         next.flag = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next;
      end
   end

   assign flag = cur.flag;

endmodule : hysteresis_flag

`default_nettype wire

// *** design/sink_control.sv ***
`timescale 1ns/10ps
`default_nettype none

// Function
// - Count rising pin edges; commit the count after the pin stays high for the latch timeout.
// - A committed count of seventeen to twenty-one selects an address; sixteen or fewer is data.
// - Counts 17 to 21 select addresses 0 to 4 in table order.
// - Each data register holds four bits; data is one to sixteen edges.
// - Data bursts of one up to sixteen edges are all accepted, except while the all-on address is selected.
// - A latched address stays selected for further data-only bursts.
// - Pin low beyond the off timeout enters shutdown, stopping sinks and converter.
// - Shutdown clears the selected address and all data registers to zero.
// - Current codes 1 to 16 give sixteen falling levels, 100 to 9.0 percent.
// - Backlight on/off: 1 both off, 2 second only, 3 first only, 4 both.
// - Aux on/off: code minus one is the binary enable pattern, sink one MSB.
// - Selecting the all-on address enables all five sinks without data.
// - Input disconnect switch closes only with valid supply after the pin went high.
// - Undervoltage lockout blocks soft start and all operation.
// - Stop switching while current limit is exceeded; resume once below.
// - Over-temperature disables both power switches; recovers below the hysteresis point.
// - Over-voltage halts switching until the sense drops below the lower threshold.

module sink_control
   import sink_ctrl_pkg::*;
#(
   parameter logic [TIMER_W-1:0] LATCH_CYCLES = LATCH_CYCLES_DEF,
   parameter logic [TIMER_W-1:0] OFF_CYCLES   = OFF_CYCLES_DEF
)
(
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               ctrl_pin,
   input  wire logic               supply_valid,
   input  wire logic               current_limit_exceeded,
   input  wire logic               overtemp_trip,
   input  wire logic               overtemp_cool,
   input  wire logic               overvoltage_above_upper,
   input  wire logic               overvoltage_below_lower,
   output var  logic               backlight_sink_one,
   output var  logic               backlight_sink_two,
   output var  logic               aux_sink_one,
   output var  logic               aux_sink_two,
   output var  logic               aux_sink_three,
   output var  logic [LEVEL_W-1:0] backlight_level,
   output var  logic [LEVEL_W-1:0] aux_level,
   output var  logic               disconnect_switch_on,
   output var  logic               soft_start_enable,
   output var  logic               power_switch_enable,
   output var  logic               shutdown_mode
);

   localparam logic [TIMER_W-1:0] LATCH_LAST = LATCH_CYCLES - TIMER_ONE;
   localparam logic [TIMER_W-1:0] OFF_LAST   = OFF_CYCLES - TIMER_ONE;

   typedef struct packed {
      power_state_type                   state;
      logic                              pin_q;
      logic [TIMER_W-1:0]                timer;
      logic [CNT_W-1:0]                  count;
      logic [2:0]                        addr;
      logic [NUM_REGS-1:0][REG_W-1:0]    regs;
      logic                              bl_one;
      logic                              bl_two;
      logic                              aux_one;
      logic                              aux_two;
      logic                              aux_three;
      logic [LEVEL_W-1:0]                bl_level;
      logic [LEVEL_W-1:0]                aux_lvl;
      logic                              disconnect;
      logic                              soft_start;
      logic                              switching;
      logic                              shutdown;
   } control_state_type;

   control_state_type cur;
   control_state_type next;

   logic overtemp_flag;
   logic overvoltage_flag;
   logic pin_edge;
   logic pin_rise;
   logic commit;
   logic off_timeout;
   logic active;

   // Maps a stored current code to the sink level in tenths of a percent.
   function automatic logic [LEVEL_W-1:0] level_of(input logic [REG_W-1:0] code);
      begin
         level_of = LEVEL_TABLE[code];
      end
   endfunction : level_of

   // Tells whether a committed count lies in the address range.
   function automatic logic is_address(input logic [CNT_W-1:0] cnt);
      begin
         is_address = (cnt >= ADDR_EDGE_FIRST) && (cnt <= ADDR_EDGE_LAST);
      end
   endfunction : is_address

   // Thermal fault with hysteresis: trip at the high point, release at the cool point.
   hysteresis_flag overtemp_hyst
   (
      .clk        (clk),
      .reset      (reset),
      .trip       (overtemp_trip),
      .release_ok (overtemp_cool),
      .flag       (overtemp_flag)
   );

   // Over-voltage with hysteresis between the upper and lower sense thresholds.
   hysteresis_flag overvoltage_hyst
   (
      .clk        (clk),
      .reset      (reset),
      .trip       (overvoltage_above_upper),
      .release_ok (overvoltage_below_lower),
      .flag       (overvoltage_flag)
   );

   always_comb
   begin
      next        = cur;
      pin_edge    = ctrl_pin != cur.pin_q;
      pin_rise    = ctrl_pin && !cur.pin_q;
      commit      = 1'b0;
      off_timeout = 1'b0;
      active      = 1'b0;

      next.pin_q = ctrl_pin;

      // The timer restarts on either edge and saturates, so a long idle never wraps.
      if (pin_edge)
      begin
         next.timer = '0;
      end
      else if (cur.timer != TIMER_FULL)
      begin
         next.timer = cur.timer + TIMER_ONE;
      end

      unique case (cur.state)
         st_off:
         begin
            // Only a rising edge with a good supply wakes the part; that edge is counted.
            if (supply_valid && pin_rise)
            begin
               next.state = st_on;
               next.count = CNT_ONE;
            end
         end
         st_on:
         begin
            off_timeout = !cur.pin_q && !pin_edge && (cur.timer == OFF_LAST);
            commit      = cur.pin_q && !pin_edge && (cur.timer == LATCH_LAST) && (cur.count != CNT_ZERO);

            if (!supply_valid || off_timeout)
            begin
               next.state = st_off;
               next.count = CNT_ZERO;
               next.addr  = ADDR_RESET;
               next.regs  = '0;
            end
            else if (pin_rise)
            begin
               // The count saturates so that a very long burst still reads as out of range.
               if (cur.count != CNT_MAX)
               begin
                  next.count = cur.count + CNT_ONE;
               end
            end
            else if (commit)
            begin
               next.count = CNT_ZERO;
               if (is_address(cur.count))
               begin
                  next.addr = 3'(cur.count - ADDR_EDGE_FIRST);
                  if (next.addr == OFS_ALL_ON)
                  begin
                     next.regs[OFS_BACKLIGHT_ONOFF] = ALL_ON_BACKLIGHT;
                     next.regs[OFS_AUX_ONOFF]       = ALL_ON_AUX;
                  end
               end
               else if (cur.count <= DATA_EDGE_MAX)
               begin
                  // Data lands in the address still selected; the all-on address has no store.
                  if (cur.addr != OFS_ALL_ON)
                  begin
                     next.regs[cur.addr] = REG_W'(cur.count) - DATA_ONE;
                  end
               end
               // Counts above the last address fall through and change nothing.
            end
         end
      endcase

      active = (next.state == st_on) && supply_valid;

      // Backlight pair: stored bit one drives the first sink, bit zero the second.
      next.bl_one = active && next.regs[OFS_BACKLIGHT_ONOFF][1];
      next.bl_two = active && next.regs[OFS_BACKLIGHT_ONOFF][0];

      // Aux trio: stored value is the binary enable pattern, first sink most significant.
      next.aux_one   = active && next.regs[OFS_AUX_ONOFF][2];
      next.aux_two   = active && next.regs[OFS_AUX_ONOFF][1];
      next.aux_three = active && next.regs[OFS_AUX_ONOFF][0];

      next.bl_level = level_of(next.regs[OFS_BACKLIGHT_CURRENT]);
      next.aux_lvl  = level_of(next.regs[OFS_AUX_CURRENT]);

      // Both power switches open on a thermal fault; the low-side one also on limit or over-voltage.
      next.disconnect = active && !overtemp_flag;
      next.soft_start = active;
      next.switching  = active && !overtemp_flag && !overvoltage_flag
                        && !current_limit_exceeded;
      next.shutdown   = !active;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cur          <= '0;
         cur.state    <= st_off;
         // The pin rests high between bursts, so a pin held high across reset must not count as a rising edge.
         cur.pin_q    <= 1'b1;
         cur.bl_level <= LEVEL_RESET;
         cur.aux_lvl  <= LEVEL_RESET;
         cur.shutdown <= 1'b1;
      end
      else
      begin
         cur <= next;
      end
   end

   assign backlight_sink_one   = cur.bl_one;
   assign backlight_sink_two   = cur.bl_two;
   assign aux_sink_one         = cur.aux_one;
   assign aux_sink_two         = cur.aux_two;
   assign aux_sink_three       = cur.aux_three;
   assign backlight_level      = cur.bl_level;
   assign aux_level            = cur.aux_lvl;
   assign disconnect_switch_on = cur.disconnect;
   assign soft_start_enable    = cur.soft_start;
   assign power_switch_enable  = cur.switching;
   assign shutdown_mode        = cur.shutdown;

endmodule : sink_control

`default_nettype wire

// *** testbench/sink_control_chk.sv ***
`timescale 1ns/10ps
`default_nettype none

module sink_control_chk
   import sink_ctrl_pkg::*;
#(
   parameter logic [TIMER_W-1:0] LATCH_CYCLES = LATCH_CYCLES_DEF,
   parameter logic [TIMER_W-1:0] OFF_CYCLES   = OFF_CYCLES_DEF
)
(
   input wire logic               clk,
   input wire logic               reset,
   input wire logic               ctrl_pin,
   input wire logic               supply_valid,
   input wire logic               current_limit_exceeded,
   input wire logic               overtemp_trip,
   input wire logic               overvoltage_above_upper,
   input wire logic               backlight_sink_one,
   input wire logic               backlight_sink_two,
   input wire logic               aux_sink_one,
   input wire logic               aux_sink_two,
   input wire logic               aux_sink_three,
   input wire logic [LEVEL_W-1:0] backlight_level,
   input wire logic [LEVEL_W-1:0] aux_level,
   input wire logic               disconnect_switch_on,
   input wire logic               soft_start_enable,
   input wire logic               power_switch_enable,
   input wire logic               shutdown_mode
);
   wire logic [4:0] sinks = {backlight_sink_one, backlight_sink_two, aux_sink_one, aux_sink_two, aux_sink_three};
   logic [TIMER_W-1:0] hi_cnt;
   logic [TIMER_W-1:0] lo_cnt;
   // Run lengths saturate, so a long idle never wraps into a false short run.
   always_ff @(posedge clk)
   begin
      hi_cnt <= (reset || !ctrl_pin) ? '0 : hi_cnt + TIMER_W'(hi_cnt != TIMER_FULL);
      lo_cnt <= (reset || ctrl_pin) ? '0 : lo_cnt + TIMER_W'(lo_cnt != TIMER_FULL);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence supply_lost;
      !supply_valid [*4];
   endsequence
   sequence off_settled;
      shutdown_mode [*2];
   endsequence
   latch_wait_a:
   assert property ($changed({sinks, backlight_level, aux_level}) && supply_valid && !shutdown_mode
      |-> hi_cnt >= LATCH_CYCLES - TIMER_ONE) else $error("outputs changed before latch pause");
   off_cause_a:
   assert property ($rose(shutdown_mode) |-> lo_cnt >= OFF_CYCLES - TIMER_ONE || !$past(supply_valid)
      || !$past(supply_valid, 2)) else $error("shutdown without long low or supply loss");
   off_reach_a:
   assert property (lo_cnt == OFF_CYCLES + TIMER_W'(3) |-> shutdown_mode) else $error("no shutdown after long low");
   shut_clear_a:
   assert property (off_settled |-> sinks == 5'h00 && backlight_level == LEVEL_RESET && aux_level == LEVEL_RESET
      && !power_switch_enable) else $error("shutdown left sinks or levels set");
   undervoltage_lockout_block_a:
   assert property (supply_lost |-> !soft_start_enable && !power_switch_enable && !disconnect_switch_on)
      else $error("operation without valid supply");
   clim_gate_a:
   assert property (current_limit_exceeded |=> !power_switch_enable) else $error("switching in current limit");
   ot_stop_a:
   assert property (overtemp_trip [*4] |-> !power_switch_enable && !disconnect_switch_on)
      else $error("switches on while overheated");
   ov_halt_a:
   assert property (overvoltage_above_upper [*4] |-> !power_switch_enable) else $error("switching in overvoltage");
endmodule : sink_control_chk

bind sink_control sink_control_chk #(.LATCH_CYCLES(LATCH_CYCLES), .OFF_CYCLES(OFF_CYCLES)) chk (.*);

`default_nettype wire

// *** testbench/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module host_model
#(
   parameter int LAT = 20
)
(
   input  wire logic clk,
   output var  logic ctrl_pin
);
   initial ctrl_pin = 1'b0;
   // Each edge is one cycle low then one high, so a low pulse stays far below the off timeout.
   task automatic send(input int n);
      repeat (n)
      begin
         @(negedge clk) ctrl_pin = 1'b0;
         @(negedge clk) ctrl_pin = 1'b1;
      end
      repeat (LAT + 4) @(negedge clk);
   endtask : send
   task automatic idle_low(input int n);
      @(negedge clk) ctrl_pin = 1'b0;
      repeat (n) @(negedge clk);
   endtask : idle_low
endmodule : host_model

`default_nettype wire

// *** testbench/pulse_count_led_sink_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module pulse_count_led_sink_control_tb
   import sink_ctrl_pkg::*;
;
   localparam logic [TIMER_W-1:0] LAT = 16'h0014;
   localparam logic [TIMER_W-1:0] OFF = 16'h001e;
   typedef struct {int a; int d; logic [4:0] s; logic [3:0] bc; logic [3:0] ac;} row_type;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic supply_valid = 1'b1;
   logic current_limit_exceeded = 1'b0;
   logic overtemp_trip = 1'b0;
   logic overtemp_cool = 1'b1;
   logic overvoltage_above_upper = 1'b0;
   logic overvoltage_below_lower = 1'b1;
   wire logic ctrl_pin;
   logic backlight_sink_one, backlight_sink_two, aux_sink_one, aux_sink_two, aux_sink_three;
   logic [LEVEL_W-1:0] backlight_level, aux_level;
   logic disconnect_switch_on, soft_start_enable, power_switch_enable, shutdown_mode;
   wire logic [4:0] sinks = {backlight_sink_one, backlight_sink_two, aux_sink_one, aux_sink_two, aux_sink_three};
   int bad_count = 0;
   int tests_run = 0;
   logic [LEVEL_W-1:0] lv [16] = '{10'h3e8, 10'h348, 10'h2c6, 10'h258, 10'h1fe, 10'h1ae, 10'h15e, 10'h136,
      10'h104, 10'h0d2, 10'h0b4, 10'h096, 10'h087, 10'h078, 10'h069, 10'h05a};
   // Address edges, data edges, then sinks {b1,b2,a1,a2,a3} and level indices; zero edges sends nothing.
   row_type rows [15] = '{
      '{19, 4, 5'h18, 0, 0}, '{19, 2, 5'h08, 0, 0}, '{19, 3, 5'h10, 0, 0}, '{19, 1, 5'h00, 0, 0},
      '{20, 8, 5'h07, 0, 0}, '{20, 5, 5'h04, 0, 0}, '{20, 2, 5'h01, 0, 0}, '{17, 16, 5'h01, 15, 0},
      '{18, 1, 5'h01, 15, 0}, '{18, 9, 5'h01, 15, 8}, '{21, 0, 5'h1f, 15, 8}, '{0, 7, 5'h1f, 15, 8},
      '{17, 2, 5'h1f, 1, 8}, '{0, 5, 5'h1f, 4, 8}, '{25, 3, 5'h1f, 2, 8}};
   // Bits: limit, trip, cool, above, below, then expected switching and disconnect.
   logic [6:0] prot [8] = '{7'h55, 7'h17, 7'h24, 7'h04, 7'h17, 7'h19, 7'h11, 7'h17};

   sink_control #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) dut (.*);
   host_model #(.LAT(int'(LAT))) host (.clk(clk), .ctrl_pin(ctrl_pin));

   initial
   begin
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [4:0] s, input logic [3:0] bc, input logic [3:0] ac);
      tests_run++;
      if (sinks !== s || backlight_level !== lv[bc] || aux_level !== lv[ac])
      begin
         bad_count++;
         $display("ERROR t=%0t sinks %b levels %0d %0d", $time, sinks, backlight_level, aux_level);
      end
   endtask : check

   task automatic check_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t flag is %b, expected %b", $time, got, exp);
      end
   endtask : check_bit

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   initial
   begin
      repeat (12) @(negedge clk);
      reset = 1'b0;
      check(5'h00, 4'h0, 4'h0);
      check_bit(disconnect_switch_on, 1'b0);
      foreach (rows[i])
      begin
         if (rows[i].a != 0) host.send(rows[i].a);
         if (rows[i].d != 0) host.send(rows[i].d);
         check(rows[i].s, rows[i].bc, rows[i].ac);
      end
      check_bit(disconnect_switch_on, 1'b1);
      check_bit(soft_start_enable, 1'b1);
      check_bit(shutdown_mode, 1'b0);
      foreach (prot[i])
      begin
         {current_limit_exceeded, overtemp_trip, overtemp_cool, overvoltage_above_upper,
            overvoltage_below_lower} = prot[i][6:2];
         repeat (4) @(negedge clk);
         check_bit(power_switch_enable, prot[i][1]);
         check_bit(disconnect_switch_on, prot[i][0]);
      end
      host.idle_low(int'(OFF) + 8);
      check_bit(shutdown_mode, 1'b1);
      check(5'h00, 4'h0, 4'h0);
      host.send(4);
      check(5'h00, 4'h3, 4'h0);
      supply_valid = 1'b0;
      host.send(21);
      check_bit(soft_start_enable, 1'b0);
      check(5'h00, 4'h0, 4'h0);
      supply_valid = 1'b1;
      host.send(21);
      check(5'h1f, 4'h0, 4'h0);
      // A reset in mid-run with the pin resting high must not leave a counted edge behind.
      reset = 1'b1;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      check(5'h00, 4'h0, 4'h0);
      repeat (4) @(negedge clk);
      check_bit(shutdown_mode, 1'b1);
      host.send(21);
      check(5'h1f, 4'h0, 4'h0);
      test_done();
   end

   // The whole sequence needs about 1,600 cycles; this bound only cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done();
   end
endmodule : pulse_count_led_sink_control_tb

`default_nettype wire
